// ### sim/infrared_pulse_codec_bench.sv
// self-checking bench for the infrared pulse codec
`timescale 1ns/10ps
`default_nettype none
module infrared_pulse_codec_bench;
  import irc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic infrared_enable = 1'b0;
  logic [1:0] pulse_width_select = 2'h0;
  logic baud_clock_source_select = 1'b0;
  logic oscillator_clock = 1'b0;
  logic serial_transmit_data = 1'b1;
  logic flash = 1'b0;
  logic ir_receive_pin, ir_transmit_pin_out, ir_transmit_pin_oe;
  logic decoded_receive_output, bit_start, tx_line, tx_q;
  int fails = 0;
  int comparisons = 0;
  int low_cnt, dec_cnt, cyc, last_fall, fall_gap;
  // divisor 1 keeps the bus clock at 32x baud, the slowest legal ratio
  irc_codec irc_codec_inst (.clk_sys(clk_sys), .rst(rst),
    .infrared_enable(infrared_enable),
    .pulse_width_select(pulse_width_select),
    .baud_clock_source_select(baud_clock_source_select),
    .oscillator_clock(oscillator_clock), .x32_divisor(16'h0001),
    .serial_transmit_data(serial_transmit_data),
    .ir_receive_pin(ir_receive_pin),
    .ir_transmit_pin_out(ir_transmit_pin_out),
    .ir_transmit_pin_oe(ir_transmit_pin_oe),
    .decoded_receive_output(decoded_receive_output),
    .bit_start(bit_start));
  irc_ir_link irc_ir_link_inst (.pin_out(ir_transmit_pin_out),
    .pin_oe(ir_transmit_pin_oe), .flash(flash), .tx_line(tx_line),
    .rx_line(ir_receive_pin));
  always #12.5 clk_sys = ~clk_sys;
  // free running oscillator, unrelated in phase to the bus clock
  initial #7 forever #25 oscillator_clock = ~oscillator_clock;
  always @(posedge clk_sys) begin
    cyc++;
    if (tx_line === 1'b0) low_cnt++;
    if (decoded_receive_output === 1'b0) dec_cnt++;
    if (tx_q === 1'b1 && tx_line === 1'b0) begin
      fall_gap = cyc - last_fall;
      last_fall = cyc;
    end
    tx_q = tx_line;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("counts: comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic send(input logic b);
    @(posedge clk_sys iff bit_start === 1'b1);
    #1 serial_transmit_data = b;
  endtask
  task automatic enc(input logic [1:0] sel, input logic src, int exp);
    pulse_width_select = sel;
    baud_clock_source_select = src;
    send(1'b1);
    send(1'b1);
    low_cnt = 0;
    send(1'b0);
    send(1'b1);
    send(1'b1);
    if (src) check(low_cnt >= 2 && low_cnt <= 3, 1);
    else check(8'(low_cnt), 8'(exp));
    $display("encode width %0d source %0d done", sel, src);
  endtask
  task automatic test_pair();
    pulse_width_select = WIDTH_1_32;
    baud_clock_source_select = 1'b0;
    send(1'b1);
    low_cnt = 0;
    send(1'b0);
    send(1'b0);
    send(1'b1);
    send(1'b1);
    check(8'(low_cnt), 8'h02);
    check(8'(fall_gap), 8'h20);
    $display("back to back zeros done");
  endtask
  task automatic blink();
    flash = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 flash = 1'b0;
  endtask
  task automatic dec(input int gap, input int lo, input int hi);
    @(posedge clk_sys);
    #1 dec_cnt = 0;
    blink();
    check(decoded_receive_output, 1'b0);
    if (gap > 0) begin
      repeat (gap - 2) @(posedge clk_sys);
      #1 blink();
    end
    repeat (70) @(posedge clk_sys);
    #1 check(dec_cnt >= lo && dec_cnt <= hi, 1);
    check(decoded_receive_output, 1'b1);
    $display("decode gap %0d done", gap);
  endtask
  // second pulse lands 1 ns after the output returns high, in the same cycle
  task automatic test_jitter();
    @(posedge clk_sys);
    #1 blink();
    @(posedge decoded_receive_output);
    #1 dec_cnt = 0;
    blink();
    repeat (10) @(posedge clk_sys);
    #1 check(8'(dec_cnt), 8'h00);
    check(decoded_receive_output, 1'b1);
    $display("jitter pulse done");
  endtask
  task automatic test_bypass();
    #1 infrared_enable = 1'b0;
    serial_transmit_data = 1'b0;
    flash = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 check({tx_line, ir_transmit_pin_oe}, 2'h1);
    check(decoded_receive_output, 1'b0);
    serial_transmit_data = 1'b1;
    flash = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 check({tx_line, decoded_receive_output}, 2'h3);
    $display("bypass done");
  endtask
  initial begin
    #500000 fails++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    check({ir_transmit_pin_oe, decoded_receive_output, bit_start},
      3'h6);
    #1 rst = 1'b0;
    test_bypass();
    infrared_enable = 1'b1;
    enc(WIDTH_1_32, 1'b0, 1);
    enc(WIDTH_1_16, 1'b0, 2);
    enc(WIDTH_3_16, 1'b0, 6);
    enc(2'h3, 1'b0, 2);
    enc(WIDTH_1_32, 1'b1, 2);
    test_pair();
    test_jitter();
    dec(0, 28, 33);
    dec(6, 28, 33);
    dec(20, 48, 53);
    end_of_test();
  end
endmodule
`default_nettype wire

// ### sim/irc_ir_link.sv
// infrared led line with pull-up and photodiode front end
`timescale 1ns/10ps
`default_nettype none
module irc_ir_link (
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic flash,
  output logic tx_line,
  output logic rx_line
);
  // released open-drain line floats to the pull-up level
  assign tx_line = pin_oe ? pin_out : 1'b1;
  // light on the photodiode pulls the receive pin low
  assign rx_line = !flash;
endmodule
`default_nettype wire

// ### src/irc_baud_ref.sv
// baud reference divider making x32 and x16 enable pulses
`timescale 1ns/10ps
`default_nettype none
module irc_baud_ref #(
  parameter int DIV_WIDTH = irc_pkg::DIV_WIDTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable,
  input wire logic oscillator_clock,
  input wire logic baud_clock_source_select,
  input wire logic [DIV_WIDTH-1:0] x32_divisor,
  output logic baud_x32_reference_clock,
  output logic baud_x16_reference_clock,
  output logic bit_start
);
  import irc_pkg::*;
  // the reset value is only as wide as the package constant
  if (DIV_WIDTH < 2 || DIV_WIDTH > $bits(DIV_RESET)) begin : g_bad_width
    $error("divider width out of range");
  end
  logic [DIV_WIDTH-1:0] count, next_count;
  logic [4:0] phase, next_phase;
  logic osc_prev, next_osc_prev;
  logic tick;
  logic next_x32, next_x16, next_bit;
  // oscillator mode: one tick per sampled rising edge of oscillator
  always_comb begin
    next_osc_prev = oscillator_clock;
    tick = baud_clock_source_select ? (oscillator_clock && !osc_prev)
                                    : 1'b1; // R15
    next_count = count;
    next_phase = phase;
    next_x32 = 1'b0;
    next_x16 = 1'b0;
    next_bit = 1'b0;
    if (!enable) begin
      next_count = '0;
      next_phase = '0;
    end else if (tick) begin
      if (count >= x32_divisor - DIV_WIDTH'(1) || x32_divisor == '0) begin
        next_count = '0;
        next_x32 = 1'b1; // R04
        next_x16 = !phase[0];
        next_bit = (phase == 5'h00);
        next_phase = phase + 5'h01;
      end else begin
        next_count = count + DIV_WIDTH'(1);
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= DIV_RESET[DIV_WIDTH-1:0];
      phase <= 5'h00;
      osc_prev <= 1'b0;
      baud_x32_reference_clock <= 1'b0;
      baud_x16_reference_clock <= 1'b0;
      bit_start <= 1'b0;
    end else begin
      count <= next_count;
      phase <= next_phase;
      osc_prev <= next_osc_prev;
      baud_x32_reference_clock <= next_x32;
      baud_x16_reference_clock <= next_x16;
      bit_start <= next_bit;
    end
  end
endmodule
`default_nettype wire

// ### src/irc_codec.sv
// infrared pulse encoder and decoder between serial unit and pins
`timescale 1ns/10ps
`default_nettype none
module irc_codec #(
  parameter int DIV_WIDTH = irc_pkg::DIV_WIDTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic infrared_enable,
  input wire logic [1:0] pulse_width_select, // R17
  input wire logic baud_clock_source_select,
  input wire logic oscillator_clock,
  input wire logic [DIV_WIDTH-1:0] x32_divisor,
  input wire logic serial_transmit_data,
  input wire logic ir_receive_pin,
  output logic ir_transmit_pin_out,
  output logic ir_transmit_pin_oe,
  output logic decoded_receive_output,
  output logic bit_start
);
  import irc_pkg::*;
  // the divider reset value is only as wide as the package constant
  if (DIV_WIDTH < 2 || DIV_WIDTH > $bits(DIV_RESET)) begin : g_bad_div
    $error("divider width out of range");
  end
  // a zero length would end the pulse on its first tick, like a length of one
  if (PULSE_X16_1 == 4'h0 || PULSE_X16_3 == 4'h0) begin : g_bad_len
    $error("zero pulse length");
  end

  // shared four-bit counter step, wraps like the hardware
  function automatic logic [3:0] step_count(input logic [3:0] value);
    return value + 4'h1;
  endfunction
  logic x32, x16, bit_tick;
  irc_baud_ref #(.DIV_WIDTH(DIV_WIDTH)) u_ref (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(infrared_enable),
    .oscillator_clock(oscillator_clock),
    .baud_clock_source_select(baud_clock_source_select),
    .x32_divisor(x32_divisor),
    .baud_x32_reference_clock(x32),
    .baud_x16_reference_clock(x16),
    .bit_start(bit_tick)
  );

  // encoder: pulse counter runs on x32 for 1/32, else on x16
  logic [3:0] pulse_cnt, next_pulse_cnt;
  logic pulse_on, next_pulse_on;
  logic next_tx_out, next_tx_oe;
  logic enc_tick;
  logic [3:0] pulse_len;
  always_comb begin
    enc_tick = (pulse_width_select == WIDTH_1_32) ? x32 : x16; // R16
    case (pulse_width_select)
      WIDTH_1_32: pulse_len = PULSE_X32_1; // R02
      WIDTH_3_16: pulse_len = PULSE_X16_3;
      // spare code 3 gives the 1/16 width
      default: pulse_len = PULSE_X16_1; // R17
    endcase
    next_pulse_cnt = pulse_cnt;
    next_pulse_on = pulse_on;
    // each zero bit opens its pulse on its bit boundary, so pulses of
    // consecutive zeros sit exactly one bit period apart
    if (bit_tick && !serial_transmit_data) begin
      next_pulse_on = 1'b1; // R01 R03
      next_pulse_cnt = '0;
    end else if (pulse_on && enc_tick) begin
      next_pulse_cnt = step_count(pulse_cnt);
      if (next_pulse_cnt >= pulse_len) next_pulse_on = 1'b0; // R02
    end
    if (!infrared_enable) begin
      next_pulse_on = 1'b0;
      next_tx_out = serial_transmit_data; // R12
      next_tx_oe = 1'b1;
    end else begin
      // open drain: drive only the low pulse, pullup gives the high
      next_tx_out = 1'b0;
      next_tx_oe = next_pulse_on; // R01
    end
  end

  // decoder, timed only by the x16 reference
  irc_dec_state_type state, next_state;
  logic [3:0] dec_cnt, next_dec_cnt;
  logic rx_prev, next_rx_prev;
  logic next_dec_out;
  logic fall;
  // high from the end of a count until the next x16 tick
  logic settle, next_settle;
  always_comb begin
    next_rx_prev = ir_receive_pin;
    fall = rx_prev && !ir_receive_pin;
    next_state = state;
    next_dec_cnt = dec_cnt;
    next_settle = settle;
    case (state)
      IRC_DEC_IDLE: begin
        // a fall before the first x16 tick after the count ended is
        // jitter; a fall on that tick is already the next zero bit
        if (fall && !(settle && !x16)) begin
          next_state = IRC_DEC_HOLD; // R07
          next_dec_cnt = '0;
        end
        if (x16) next_settle = 1'b0; // R11
      end
      IRC_DEC_HOLD: begin
        if (x16) next_dec_cnt = step_count(dec_cnt); // R05 R06 R08
        if (x16 && dec_cnt == CNT_HALF) next_state = IRC_DEC_OPEN;
      end
      IRC_DEC_OPEN: begin
        if (fall) begin
          next_state = IRC_DEC_HOLD; // R09
          next_dec_cnt = '0;
        end else if (x16) begin
          next_dec_cnt = step_count(dec_cnt);
          if (next_dec_cnt == CNT_LAST) begin
            next_state = IRC_DEC_IDLE; // R10
            next_settle = 1'b1; // R11
          end
        end
      end
      default: next_state = IRC_DEC_IDLE;
    endcase
    // R14: serial unit sees plain levels either way
    next_dec_out = infrared_enable ? (next_state == IRC_DEC_IDLE)
                                   : ir_receive_pin; // R12
    if (!infrared_enable) begin
      next_state = IRC_DEC_IDLE;
      next_settle = 1'b0;
      next_dec_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulse_cnt <= 4'h0;
      pulse_on <= 1'b0;
      ir_transmit_pin_out <= 1'b1;
      ir_transmit_pin_oe <= 1'b1;
      state <= IRC_DEC_IDLE;
      dec_cnt <= 4'h0;
      rx_prev <= 1'b1;
      settle <= 1'b0;
      decoded_receive_output <= 1'b1;
      bit_start <= 1'b0;
    end else begin
      pulse_cnt <= next_pulse_cnt;
      pulse_on <= next_pulse_on;
      ir_transmit_pin_out <= next_tx_out;
      ir_transmit_pin_oe <= next_tx_oe;
      state <= next_state;
      dec_cnt <= next_dec_cnt;
      rx_prev <= next_rx_prev;
      settle <= next_settle;
      decoded_receive_output <= next_dec_out;
      bit_start <= bit_tick;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  bypass_tx_a: assert property (!infrared_enable |=> // R12
    ir_transmit_pin_out == $past(serial_transmit_data))
    else $error("bypass transmit mismatch");
  bypass_rx_a: assert property (!infrared_enable |=> // R12
    decoded_receive_output == $past(ir_receive_pin))
    else $error("bypass receive mismatch");
  zero_pulse_a: assert property (infrared_enable && bit_tick && // R01
    !serial_transmit_data |=> ir_transmit_pin_oe && !ir_transmit_pin_out)
    else $error("zero bit gave no pulse");
  one_quiet_a: assert property (infrared_enable && !pulse_on |-> // R01
    !ir_transmit_pin_oe || $past(!infrared_enable))
    else $error("pin driven with no pulse");
  start_low_a: assert property (infrared_enable && state == IRC_DEC_IDLE // R07
    && fall && !(settle && !x16) |=> !decoded_receive_output)
    else $error("decoder did not go low");
  hold_low_a: assert property (infrared_enable && state == IRC_DEC_HOLD // R08
    |=> !decoded_receive_output || !infrared_enable)
    else $error("output high during hold");
  count_range_a: assert property (state == IRC_DEC_HOLD |-> // R06
    dec_cnt <= CNT_HALF)
    else $error("hold count above seven");
  restart_a: assert property (infrared_enable && state == IRC_DEC_OPEN // R09
    && fall |=> state == IRC_DEC_HOLD && dec_cnt == 4'h0)
    else $error("open pulse did not restart");
  end_high_a: assert property (infrared_enable && state == IRC_DEC_OPEN // R10
    && x16 && !fall && dec_cnt == 4'hE |=> state == IRC_DEC_IDLE
    ##0 decoded_receive_output)
    else $error("decoder did not end at 15");
  jitter_a: assert property (infrared_enable && state == IRC_DEC_IDLE // R11
    && fall && settle && !x16 |=> decoded_receive_output)
    else $error("jitter pulse reached the output");
  idle_high_a: assert property (infrared_enable // R10
    && state == IRC_DEC_IDLE && !fall |=> decoded_receive_output)
    else $error("output low while idle");
  open_count_a: assert property (state == IRC_DEC_OPEN |-> // R09
    dec_cnt > CNT_HALF)
    else $error("open count not past seven");
  count_halt_a: assert property (infrared_enable // R10
    && state == IRC_DEC_IDLE && !fall |=> $stable(dec_cnt))
    else $error("counter moved while halted");
  step_x16_a: assert property (infrared_enable // R05
    && state != IRC_DEC_IDLE && !x16 && !fall |=> $stable(dec_cnt))
    else $error("counter moved without x16 tick");
  pulse_start_a: assert property (infrared_enable && !bit_tick // R03 R16
    && !pulse_on |=> !pulse_on)
    else $error("pulse began off the bit boundary");
  pulse_cv: cover property (bit_tick && !serial_transmit_data
    && infrared_enable);
  restart_cv: cover property (state == IRC_DEC_OPEN && fall);
  finish_cv: cover property (state == IRC_DEC_OPEN ##1
    state == IRC_DEC_IDLE);
  jitter_cv: cover property (state == IRC_DEC_IDLE && fall && settle
    && !x16);
  ignore_cv: cover property (state == IRC_DEC_HOLD && fall);
endmodule
`default_nettype wire

// ### src/irc_pkg.sv
// constants and types for the infrared pulse codec
// Function
// R01: zero bits become narrow low transmit pulses
// R02: pulse width selectable 1/32, 1/16, 3/16 bit
// R03: back to back zero pulses one bit apart
// R04: x16 and x32 baud references feed encoder
// R05: decoder timed by x16 reference only
// R06: decoder has four-bit counter zero to 15
// R07: idle pulse starts counter, output low at once
// R08: pulses ignored while counter 0 to 7
// R09: pulse after count 7 restarts counter
// R10: at 15 output high, counter halts
// R11: pulse just after terminal count is jitter
// R12: disabled path passes pins straight through
// R13: software keeps bus clock at least 32x baud
// R14: serial unit always sees plain serial data
// R15: baud clock from bus or oscillator clock
// R16: 1/32 from x32, others from x16 reference
// R17: enable and two-bit width select inputs
package irc_pkg;
  localparam logic [1:0] WIDTH_1_32 = 2'h0;
  localparam logic [1:0] WIDTH_1_16 = 2'h1;
  localparam logic [1:0] WIDTH_3_16 = 2'h2;
  localparam logic [3:0] CNT_LAST = 4'hF;
  localparam logic [3:0] CNT_HALF = 4'h7;
  localparam logic [3:0] PULSE_X16_1 = 4'h1;
  localparam logic [3:0] PULSE_X16_3 = 4'h3;
  localparam logic [3:0] PULSE_X32_1 = 4'h1;
  localparam logic [3:0] X16_PER_BIT = 4'hF;
  localparam int DIV_WIDTH = 16;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  typedef enum logic [1:0] {
    IRC_DEC_IDLE = 2'b00,
    IRC_DEC_HOLD = 2'b01,
    IRC_DEC_OPEN = 2'b11
  } irc_dec_state_type;
endpackage
